//--- design/twmt_master.v
// Two-wire serial master transmitter with an AHB-Lite register slave.
// Assumes one clock (hclk as oscillator clock), open-drain pads outside,
// and synchronous scl_i and sda_i inputs.
`timescale 1ns/10ps
`default_nettype none
`include "twmt_map.vh"

module twmt_master (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_r,
  output reg         hreadyout_r,
  output reg         hresp_r,
  input  wire        scl_i,
  output reg         scl_o_r,
  output reg         scl_oe_r,
  input  wire        sda_i,
  output reg         sda_o_r,
  output reg         sda_oe_r
);

  localparam S_IDLE  = 3'd0;
  localparam S_START = 3'd1;
  localparam S_BYTE  = 3'd2;
  localparam S_HOLD  = 3'd3;
  localparam S_STOP  = 3'd4;
  localparam S_LOST  = 3'd5;

  // Control fields of serial_control_reg, then the data, reload and status-code registers.
  reg  [2:0]  rate_sel_r;
  reg         en_r;
  reg         start_request_flag_r;
  reg         stop_request_flag_r;
  reg         serial_irq_flag_r;
  reg         assert_ack_flag_r;
  reg  [7:0]  serial_data_reg_r;
  reg  [7:0]  reload_r;
  reg  [7:0]  code_r;

  // Sequencer state.
  reg  [2:0]  state_r;
  reg  [1:0]  ph_r;
  reg  [3:0]  bit_r;
  reg  [7:0]  shift_r;
  reg         is_addr_r;
  reg         addr_rd_r;
  reg         rx_mode_r;
  reg         restart_r;
  reg         ack_r;
  reg         busy_r;
  reg         scl_q_r;
  reg         sda_q_r;

  // Bus slave state.
  reg         wr_pend_r;
  reg  [7:0]  wr_addr_r;

  wire        qtick;
  wire        acc;
  wire        wr_ctrl;
  wire        wr_data;
  wire        wr_reload;
  wire        sw_sets_stop;
  wire        start_det;
  wire        stop_det;
  wire [7:0]  ctrl_rd;
  wire [7:0]  stat_rd;

  // ----------------------------------------------------------------------------
  // Bit-rate generator
  // ----------------------------------------------------------------------------
  twmt_rate_gen u_rate (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (en_r),
    .rate_sel (rate_sel_r),
    .reload   (reload_r),
    .qtick_r  (qtick)
  );

  // ----------------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------------
  // Zero-wait slave: reads are sampled at the address phase so data stand in
  // the data phase; writes land at the end of the data phase.
  assign acc       = hsel && hready && htrans[1];
  assign wr_ctrl   = wr_pend_r && (wr_addr_r == `TWMT_OFS_CTRL);
  assign wr_data   = wr_pend_r && (wr_addr_r == `TWMT_OFS_DATA);
  assign wr_reload = wr_pend_r && (wr_addr_r == `TWMT_OFS_RELOAD);
  assign sw_sets_stop = wr_ctrl && hwdata[`TWMT_B_STO];

  assign ctrl_rd = {rate_sel_r[2], en_r, start_request_flag_r, stop_request_flag_r,
                    serial_irq_flag_r, assert_ack_flag_r, rate_sel_r[1:0]};
  assign stat_rd = serial_irq_flag_r ? code_r : `TWMT_ST_NONE;

  // Read data and the fixed OKAY answer; unmapped reads return zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      wr_pend_r   <= acc && hwrite;
      if (acc) begin
        wr_addr_r <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        case (haddr[7:0])
          `TWMT_OFS_CTRL:   hrdata_r <= {24'h00_0000, ctrl_rd};
          `TWMT_OFS_DATA:   hrdata_r <= {24'h00_0000, serial_data_reg_r};
          `TWMT_OFS_STAT:   hrdata_r <= {24'h00_0000, stat_rd};
          `TWMT_OFS_RELOAD: hrdata_r <= {24'h00_0000, reload_r};
          default:          hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Bus-free monitor
  // ----------------------------------------------------------------------------
  // START and STOP seen on the wires, from any master, track bus ownership.
  assign start_det = scl_i && scl_q_r && sda_q_r && !sda_i;
  assign stop_det  = scl_i && scl_q_r && !sda_q_r && sda_i;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      if (start_det) begin
        busy_r <= 1'b1;
      end else if (stop_det) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Plain registers written by software only
  // ----------------------------------------------------------------------------
  // The pads are open drain, so the driven level is always low.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_data_reg_r <= `TWMT_DATA_RST;
      reload_r          <= `TWMT_RELOAD_RST;
      rate_sel_r        <= 3'b000;
      en_r              <= 1'b0;
      assert_ack_flag_r <= 1'b0;
      scl_o_r           <= 1'b0;
      sda_o_r           <= 1'b0;
    end else begin
      if (wr_data) begin
        serial_data_reg_r <= hwdata[7:0];
      end
      if (wr_reload) begin
        reload_r <= hwdata[7:0];
      end
      if (wr_ctrl) begin
        rate_sel_r        <= {hwdata[`TWMT_B_RS2], hwdata[`TWMT_B_RS1], hwdata[`TWMT_B_RS0]};
        en_r              <= hwdata[`TWMT_B_EN];
        assert_ack_flag_r <= hwdata[`TWMT_B_AA];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Flags and bus sequencer
  // ----------------------------------------------------------------------------
  // Software writes come first and the sequencer's own updates follow, so a
  // hardware event in the cycle of a software clear still sets the flag.
  // Each bit takes four quarters: data set, clock released, sample, clock low.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_request_flag_r <= 1'b0;
      stop_request_flag_r  <= 1'b0;
      serial_irq_flag_r    <= 1'b0;
      code_r               <= `TWMT_ST_NONE;
      state_r              <= S_IDLE;
      ph_r                 <= 2'b00;
      bit_r                <= 4'h0;
      shift_r              <= 8'h00;
      is_addr_r            <= 1'b0;
      addr_rd_r            <= 1'b0;
      rx_mode_r            <= 1'b0;
      restart_r            <= 1'b0;
      ack_r                <= 1'b0;
      scl_oe_r             <= 1'b0;
      sda_oe_r             <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        start_request_flag_r <= hwdata[`TWMT_B_STA];
        stop_request_flag_r  <= hwdata[`TWMT_B_STO];
        serial_irq_flag_r    <= serial_irq_flag_r & hwdata[`TWMT_B_IRQ];
      end
      if (!en_r) begin
        // A disabled unit lets go of both lines at once.
        state_r  <= S_IDLE;
        ph_r     <= 2'b00;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          S_IDLE: begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            // Wait for a free bus before claiming it.
            if (start_request_flag_r && !serial_irq_flag_r && !busy_r) begin
              state_r   <= S_START;
              ph_r      <= 2'b00;
              restart_r <= 1'b0;
            end
          end
          S_START: if (qtick) begin
            case (ph_r)
              2'b00: begin
                sda_oe_r <= 1'b0;
                ph_r     <= 2'b01;
              end
              2'b01: begin
                scl_oe_r <= 1'b0;
                ph_r     <= 2'b10;
              end
              2'b10: begin
                // Clock stretching or a busy data line delays the START.
                if (scl_i && sda_i) begin
                  sda_oe_r <= 1'b1;
                  ph_r     <= 2'b11;
                end
              end
              default: begin
                scl_oe_r          <= 1'b1;
                serial_irq_flag_r <= 1'b1;
                code_r    <= restart_r ? `TWMT_ST_RESTART : `TWMT_ST_START;
                is_addr_r <= 1'b1;
                rx_mode_r <= 1'b0;
                state_r   <= S_HOLD;
                ph_r      <= 2'b00;
              end
            endcase
          end
          S_HOLD: begin
            // The clock stays low until software clears the flag.
            if (!serial_irq_flag_r && qtick) begin
              if (is_addr_r) begin
                // After a START only an address may follow.
                shift_r   <= serial_data_reg_r;
                addr_rd_r <= serial_data_reg_r[0];
                bit_r     <= 4'h0;
                state_r   <= S_BYTE;
              end else if (stop_request_flag_r) begin
                state_r <= S_STOP;
              end else if (start_request_flag_r) begin
                state_r   <= S_START;
                restart_r <= 1'b1;
              end else begin
                shift_r <= serial_data_reg_r;
                bit_r   <= 4'h0;
                state_r <= S_BYTE;
              end
              ph_r <= 2'b00;
            end
          end
          S_BYTE: if (qtick) begin
            case (ph_r)
              2'b00: begin
                // The ninth bit leaves the data line free for the acknowledge.
                sda_oe_r <= (bit_r == `TWMT_LAST_BIT) ? 1'b0 : ~shift_r[7];
                ph_r     <= 2'b01;
              end
              2'b01: begin
                scl_oe_r <= 1'b0;
                ph_r     <= 2'b10;
              end
              2'b10: begin
                if (scl_i) begin
                  if (bit_r != `TWMT_LAST_BIT && !sda_oe_r && !sda_i) begin
                    // Another master drove a zero over our one.
                    scl_oe_r          <= 1'b0;
                    serial_irq_flag_r <= 1'b1;
                    code_r            <= `TWMT_ST_LOST;
                    state_r           <= S_LOST;
                    ph_r              <= 2'b00;
                  end else begin
                    ack_r <= !sda_i;
                    ph_r  <= 2'b11;
                  end
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                ph_r     <= 2'b00;
                if (bit_r == `TWMT_LAST_BIT) begin
                  serial_irq_flag_r <= 1'b1;
                  is_addr_r         <= 1'b0;
                  state_r           <= S_HOLD;
                  if (is_addr_r && addr_rd_r) begin
                    rx_mode_r <= 1'b1;
                    code_r    <= ack_r ? `TWMT_ST_AR_ACK : `TWMT_ST_AR_NACK;
                  end else if (is_addr_r) begin
                    code_r <= ack_r ? `TWMT_ST_AW_ACK : `TWMT_ST_AW_NACK;
                  end else begin
                    code_r <= ack_r ? `TWMT_ST_D_ACK : `TWMT_ST_D_NACK;
                  end
                end else begin
                  shift_r <= {shift_r[6:0], 1'b0};
                  bit_r   <= bit_r + 4'h1;
                end
              end
            endcase
          end
          S_STOP: if (qtick) begin
            case (ph_r)
              2'b00: begin
                sda_oe_r <= 1'b1;
                ph_r     <= 2'b01;
              end
              2'b01: begin
                scl_oe_r <= 1'b0;
                ph_r     <= 2'b10;
              end
              2'b10: begin
                if (scl_i) begin
                  sda_oe_r <= 1'b0;
                  ph_r     <= 2'b11;
                end
              end
              default: begin
                // A pending start is taken up from idle once the bus is free.
                if (!sw_sets_stop) begin
                  stop_request_flag_r <= 1'b0;
                end
                state_r <= S_IDLE;
                ph_r    <= 2'b00;
              end
            endcase
          end
          S_LOST: begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            // Idle with start clear is the not-addressed slave; with start set
            // it waits for a free bus and starts again.
            if (!serial_irq_flag_r) begin
              state_r <= S_IDLE;
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // twmt_master

`default_nettype wire

//--- design/twmt_rate_gen.v
// Quarter-bit tick generator for the two-wire master transmitter.
// Assumes hclk is the oscillator clock; the divisor follows the rate select.
`timescale 1ns/10ps
`default_nettype none
`include "twmt_map.vh"

module twmt_rate_gen (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        run,
  input  wire [2:0]  rate_sel,
  input  wire [7:0]  reload,
  output reg         qtick_r
);

  reg  [15:0] div;
  reg  [15:0] cnt_r;
  wire [15:0] qtr;

  // ----------------------------------------------------------------------------
  // Divisor selection
  // ----------------------------------------------------------------------------
  // Code 100 defines no rate, so it yields no ticks and the sequencer stalls.
  always @* begin
    case (rate_sel)
      3'b000:  div = `TWMT_DIV_000;
      3'b001:  div = `TWMT_DIV_001;
      3'b010:  div = `TWMT_DIV_010;
      3'b011:  div = `TWMT_DIV_011;
      3'b101:  div = `TWMT_DIV_101;
      3'b110:  div = `TWMT_DIV_110;
      3'b111:  div = `TWMT_T1_MUL * (`TWMT_T1_TOP - {8'h00, reload});
      default: div = `TWMT_DIV_NONE;
    endcase
  end

  // Every bit spans four quarters, so the counter runs a quarter of the divisor.
  assign qtr = div >> `TWMT_QTR_SHIFT;

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // A stopped or undefined rate keeps the counter parked at zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= 16'h0000;
      qtick_r <= 1'b0;
    end else if (!run || qtr == 16'h0000) begin
      cnt_r   <= 16'h0000;
      qtick_r <= 1'b0;
    end else if (cnt_r >= qtr - 16'h0001) begin
      cnt_r   <= 16'h0000;
      qtick_r <= 1'b1;
    end else begin
      cnt_r   <= cnt_r + 16'h0001;
      qtick_r <= 1'b0;
    end
  end

endmodule // twmt_rate_gen

`default_nettype wire

//--- include/twmt_map.vh
// Constants for the two-wire master transmitter: register offsets, control
// field positions, reset values, status codes and bit-rate divisors.
// Included by the design files by bare name; holds definitions only.
`ifndef TWMT_MAP_VH
`define TWMT_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define TWMT_OFS_CTRL    8'h00
`define TWMT_OFS_DATA    8'h04
`define TWMT_OFS_STAT    8'h08
`define TWMT_OFS_RELOAD  8'h0C

// ----------------------------------------------------------------------------
// Field positions inside serial_control_reg
// ----------------------------------------------------------------------------
`define TWMT_B_RS0  0
`define TWMT_B_RS1  1
`define TWMT_B_AA   2
`define TWMT_B_IRQ  3
`define TWMT_B_STO  4
`define TWMT_B_STA  5
`define TWMT_B_EN   6
`define TWMT_B_RS2  7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TWMT_CTRL_RST    8'h00
`define TWMT_DATA_RST    8'h00
`define TWMT_RELOAD_RST  8'h00

// ----------------------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------------------
`define TWMT_ST_START    8'h08
`define TWMT_ST_RESTART  8'h10
`define TWMT_ST_AW_ACK   8'h18
`define TWMT_ST_AW_NACK  8'h20
`define TWMT_ST_D_ACK    8'h28
`define TWMT_ST_D_NACK   8'h30
`define TWMT_ST_LOST     8'h38
`define TWMT_ST_AR_ACK   8'h40
`define TWMT_ST_AR_NACK  8'h48
`define TWMT_ST_NONE     8'hF8

// ----------------------------------------------------------------------------
// Oscillator divisors per rate select, and the timer-mode factor
// ----------------------------------------------------------------------------
`define TWMT_DIV_000     16'h0100
`define TWMT_DIV_001     16'h00E0
`define TWMT_DIV_010     16'h00C0
`define TWMT_DIV_011     16'h00A0
`define TWMT_DIV_101     16'h0078
`define TWMT_DIV_110     16'h003C
`define TWMT_DIV_NONE    16'h0000
`define TWMT_T1_MUL      16'h0060
`define TWMT_T1_TOP      16'h0100
`define TWMT_QTR_SHIFT   2
`define TWMT_LAST_BIT    4'h8

`endif

//--- verif/tb_twi_master_transmitter.sv
// Testbench: register accesses over AHB-Lite drive write transfers to a slave model.
// Assumes the design header is on the include path and one slave on the bus.
`timescale 1ns/10ps
`default_nettype none
`include "twmt_map.vh"
module tb_twi_master_transmitter;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0]  mode;
  logic [2:0]  rate;
  logic [31:0] rd;
  wire  [31:0] hrdata_r;
  wire         hreadyout_r, hresp_r, scl_o_r, scl_oe_r, sda_o_r, sda_oe_r, slv_oe;
  wire  [7:0]  rx_byte;
  wire         scl_w = ~scl_oe_r;
  wire         sda_w = ~(sda_oe_r | slv_oe);
  int          fails;
  int          check_count;
  int          cyc = 0;
  int          t0;
  logic [7:0]  ofs [5] = '{`TWMT_OFS_CTRL, `TWMT_OFS_DATA, `TWMT_OFS_RELOAD, `TWMT_OFS_STAT, 8'h10};
  logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h00, `TWMT_ST_NONE, 8'h00};
  logic [2:0]  rates [7] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b101, 3'b110, 3'b111};
  logic [15:0] divs [7] = '{16'h0100, 16'h00E0, 16'h00C0, 16'h00A0, 16'h0078, 16'h003C, 16'h00C0};
  twmt_master DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_r),
    .hrdata_r(hrdata_r), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r), .scl_i(scl_w),
    .scl_o_r(scl_o_r), .scl_oe_r(scl_oe_r), .sda_i(sda_w), .sda_o_r(sda_o_r),
    .sda_oe_r(sda_oe_r));
  twmt_slave_model u_slave (.hclk(hclk), .scl(scl_w), .sda(sda_w), .mode(mode),
    .sda_oe(slv_oe), .rx_byte(rx_byte));
  // Free-running bus clock.
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Cycle count for timing bytes.
  always @(posedge hclk) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single transfer; both phases wait for ready, read data taken at the last edge.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, we, 24'h00_0000, a};
    do @(posedge hclk); while (hreadyout_r !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h00_0000, d};
    do @(posedge hclk); while (hreadyout_r !== 1'b1);
    rd = hrdata_r;
  endtask
  function automatic logic [7:0] ctl(input logic s, input logic p);
    return {rate[2], 1'b1, s, p, 2'b00, rate[1:0]};
  endfunction
  task automatic go(input logic s, input logic p);
    xfer(1'b1, `TWMT_OFS_CTRL, ctl(s, p));
  endtask
  // Polls the status word until a code other than idle shows, within a bound.
  task automatic wait_st(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `TWMT_OFS_STAT, 8'h00);
      n++;
    end while (rd[7:0] === `TWMT_ST_NONE && n < 3000);
    chk("status", rd[7:0], exp);
  endtask
  // Sends a stop and waits until the stop request clears itself.
  task automatic stop_done;
    int n;
    go(1'b0, 1'b1);
    n = 0;
    do begin
      xfer(1'b0, `TWMT_OFS_CTRL, 8'h00);
      n++;
    end while (rd[`TWMT_B_STO] !== 1'b0 && n < 3000);
    chk("control", rd[7:0], ctl(1'b0, 1'b0));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {hsize, mode, rate, fails, check_count} = {3'b010, 2'b00, 3'b110, 64'h0};
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, `TWMT_OFS_STAT, `TWMT_ST_D_ACK);
    foreach (ofs[i]) begin
      xfer(1'b0, ofs[i], 8'h00);
      chk("reset word", rd[7:0], rv[i]);
    end
    $display("test reset done");
    xfer(1'b1, `TWMT_OFS_RELOAD, 8'hFE);
    foreach (rates[i]) begin
      rate = rates[i];
      go(1'b1, 1'b0);
      wait_st(`TWMT_ST_START);
      xfer(1'b1, `TWMT_OFS_DATA, 8'hA6);
      t0 = cyc;
      go(1'b0, 1'b0);
      wait_st(`TWMT_ST_AW_ACK);
      chk("bit time", 8'((cyc - t0) / divs[i]), 8'h09);
      chk("slave byte", rx_byte, 8'hA6);
      stop_done();
    end
    $display("test rates done");
    rate = 3'b110;
    go(1'b1, 1'b0);
    wait_st(`TWMT_ST_START);
    xfer(1'b1, `TWMT_OFS_DATA, 8'hA6);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_AW_ACK);
    chk("clock hold", {7'h00, scl_oe_r}, 8'h01);
    xfer(1'b1, `TWMT_OFS_DATA, 8'h5A);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_D_ACK);
    chk("slave byte", rx_byte, 8'h5A);
    mode <= 2'd1;
    xfer(1'b1, `TWMT_OFS_DATA, 8'h3C);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_D_NACK);
    go(1'b1, 1'b0);
    wait_st(`TWMT_ST_RESTART);
    xfer(1'b1, `TWMT_OFS_DATA, 8'hA6);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_AW_NACK);
    go(1'b1, 1'b1);
    wait_st(`TWMT_ST_START);
    xfer(1'b0, `TWMT_OFS_CTRL, 8'h00);
    chk("control", rd[7:0], ctl(1'b1, 1'b0) | 8'h08);
    mode <= 2'd0;
    xfer(1'b1, `TWMT_OFS_DATA, 8'hA7);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_AR_ACK);
    stop_done();
    $display("test sequence done");
    mode <= 2'd2;
    go(1'b1, 1'b0);
    wait_st(`TWMT_ST_START);
    xfer(1'b1, `TWMT_OFS_DATA, 8'hA6);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_LOST);
    go(1'b0, 1'b0);
    xfer(1'b0, `TWMT_OFS_STAT, 8'h00);
    chk("status", rd[7:0], `TWMT_ST_NONE);
    chk("line drive", {6'h00, scl_oe_r, sda_oe_r}, 8'h00);
    go(1'b1, 1'b0);
    repeat (100) @(posedge hclk);
    xfer(1'b0, `TWMT_OFS_STAT, 8'h00);
    chk("status", rd[7:0], `TWMT_ST_NONE);
    mode <= 2'd0;
    wait_st(`TWMT_ST_START);
    go(1'b0, 1'b0);
    wait_st(`TWMT_ST_AW_ACK);
    stop_done();
    $display("test arbitration done");
    end_of_test();
  end
  // Watchdog: well beyond the longest expected run.
  initial begin
    repeat (100000) @(posedge hclk);
    fails++;
    end_of_test();
  end
endmodule // tb_twi_master_transmitter
`default_nettype wire

//--- verif/twmt_props.sv
// Checker for the two-wire master: bus answer, open-drain pins, clock timing.
// Assumes it is bound to twmt_master and the slave never stretches the clock.
`timescale 1ns/10ps
`default_nettype none
`include "twmt_map.vh"
module twmt_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata_r,
  input wire logic        hreadyout_r,
  input wire logic        hresp_r,
  input wire logic        scl_i,
  input wire logic        scl_o_r,
  input wire logic        scl_oe_r,
  input wire logic        sda_o_r,
  input wire logic        sda_oe_r
);
  logic        wr_r;
  logic [7:0]  wa_r;
  logic [7:0]  rel_r;
  logic [2:0]  rs_r;
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [15:0] qtr;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // Shadow state
  // ----
  // Rate and reload are shadowed, because the quarter length follows them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r  <= 1'b0;
      wa_r  <= 8'h00;
      rel_r <= 8'h00;
      rs_r  <= 3'b000;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      wa_r <= haddr[7:0];
      if (wr_r && wa_r == `TWMT_OFS_CTRL) rs_r <= {hwdata[7], hwdata[1:0]};
      if (wr_r && wa_r == `TWMT_OFS_RELOAD) rel_r <= hwdata[7:0];
    end
  end
  // Spells of the driven clock; they saturate so a long idle cannot wrap.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
    end else begin
      hi_r <= scl_oe_r ? 16'h0000 : hi_r + {15'h0000, ~&hi_r};
      lo_r <= scl_oe_r ? lo_r + {15'h0000, ~&lo_r} : 16'h0000;
    end
  end
  // Quarter-bit length; code 100 has none, so its timing goes unchecked.
  always_comb begin
    case (rs_r)
      3'b000:  qtr = `TWMT_DIV_000 >> `TWMT_QTR_SHIFT;
      3'b001:  qtr = `TWMT_DIV_001 >> `TWMT_QTR_SHIFT;
      3'b010:  qtr = `TWMT_DIV_010 >> `TWMT_QTR_SHIFT;
      3'b011:  qtr = `TWMT_DIV_011 >> `TWMT_QTR_SHIFT;
      3'b101:  qtr = `TWMT_DIV_101 >> `TWMT_QTR_SHIFT;
      3'b110:  qtr = `TWMT_DIV_110 >> `TWMT_QTR_SHIFT;
      3'b111:  qtr = (`TWMT_T1_MUL * (`TWMT_T1_TOP - {8'h00, rel_r})) >> `TWMT_QTR_SHIFT;
      default: qtr = 16'h0000;
    endcase
  end
  sequence s_start;
    $rose(sda_oe_r) && scl_i;
  endsequence
  sequence s_stop;
    $fell(sda_oe_r) && scl_i;
  endsequence
  a_bus_okay: assert property (hreadyout_r && !hresp_r)
    else $error("bus answer not ready or not okay");
  a_pins_drain: assert property (!scl_o_r && !sda_o_r)
    else $error("pin driven high");
  a_rdata_byte: assert property (hrdata_r[31:8] == '0)
    else $error("read data upper bits set");
  a_start_held: assert property (s_start |-> ##[1:1000] scl_oe_r)
    else $error("clock not pulled low after start");
  a_stop_free: assert property (s_stop |=> (!scl_oe_r && !sda_oe_r) [*8])
    else $error("lines not free after stop");
  a_high_time: assert property ($rose(scl_oe_r) && hi_r < 3 * qtr |-> hi_r == 2 * qtr)
    else $error("clock high time wrong");
  a_low_time: assert property ($fell(scl_oe_r) |-> lo_r >= 2 * qtr)
    else $error("clock low time short");
  a_edges_apart: assert property ($changed(sda_oe_r) |-> !$changed(scl_oe_r))
    else $error("data and clock moved together");
endmodule // twmt_props
bind twmt_master twmt_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata_r, .hreadyout_r, .hresp_r, .scl_i, .scl_o_r, .scl_oe_r,
  .sda_o_r, .sda_oe_r);
`default_nettype wire

//--- verif/twmt_slave_model.sv
// Slave on the two-wire bus: shifts bytes in, acks or not, or fights.
// Assumes the bench wires open-drain lines with pull-ups; mode 0 ack, 1 nack, 2 fight.
`timescale 1ns/10ps
`default_nettype none
module twmt_slave_model (
  input  wire logic       hclk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [1:0] mode,
  output wire logic       sda_oe,
  output var  logic [7:0] rx_byte
);
  logic       scl_p = 1'b1;
  logic       sda_p = 1'b1;
  logic       ack_r = 1'b0;
  logic       fr_r  = 1'b0;
  logic [3:0] cnt_r = 4'h0;
  logic [7:0] sr_r  = 8'h00;
  // Fight mode holds the data line low for the whole frame to win arbitration.
  assign sda_oe = ack_r | (mode == 2'd2 && fr_r);
  initial rx_byte = 8'h00;
  // Edges are seen by oversampling; a start restarts the bit count.
  always @(posedge hclk) begin
    scl_p <= scl;
    sda_p <= sda;
    if (scl && sda_p && !sda) begin
      fr_r  <= 1'b1;
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (scl && !sda_p && sda) begin
      fr_r <= 1'b0;
    end else if (!scl_p && scl && cnt_r < 4'h8) begin
      sr_r  <= {sr_r[6:0], sda};
      cnt_r <= cnt_r + 4'h1;
    end else if (scl_p && !scl && cnt_r == 4'h8) begin
      ack_r   <= (mode == 2'd0);
      cnt_r   <= 4'h9;
      rx_byte <= sr_r;
    end else if (scl_p && !scl && cnt_r == 4'h9) begin
      ack_r <= 1'b0;
      cnt_r <= 4'h0;
    end
  end
endmodule // twmt_slave_model
`default_nettype wire
